/* File: rtl/instr_timing_unit.sv */
// instruction timing unit: looks up, sums and runs out the clocks of one instruction
`default_nettype none

module instr_timing_unit
  import timing_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire op_type op_in,
  input wire logic [COUNT_W-1:0] count_in,
  input wire disp_type disp_size_in,
  input wire logic long_operand_in,
  input wire logic branch_taken_in,
  input wire logic cond_true_in,
  input wire logic counter_expired_in,
  input wire logic loop_mode_in,
  input wire logic exception_in,
  input wire logic [EA_W-1:0] ea_clocks_in,
  input wire logic [EA_W-1:0] imm_clocks_in,
  output logic busy_out,
  output logic done_out,
  output logic [TOTAL_W-1:0] total_out,
  output logic [TOTAL_W-1:0] run_clocks_out,
  output logic signed [7:0] head_out,
  output logic signed [7:0] tail_out,
  output logic [3:0] reads_out,
  output logic [3:0] prefetches_out,
  output logic [3:0] writes_out,
  output logic [7:0] bus_clocks_out
);

  // ---------------------------------------------------------------
  // lookup functions
  // ---------------------------------------------------------------
  function automatic timing_entry_type select_entry(
    input op_type op,
    input disp_type disp,
    input logic taken,
    input logic cond_true,
    input logic expired,
    input logic loop_mode,
    input logic exc
  );
    timing_entry_type e;
    e = E_SHIFT_REG;
    case (op)
      OP_SHIFT_REG: e = E_SHIFT_REG;
      OP_ROX_REG: e = E_SHIFT_REG;
      OP_ROX_IMM: e = E_SHIFT_REG;
      OP_SHIFT_IMM: e = E_SHIFT_IMM;
      OP_SHIFT_MEM: e = E_SHIFT_MEM;
      OP_BIT_IMM_REG: e = E_BIT_IMM_REG;
      OP_BIT_REG_REG: e = E_BIT_REG_REG;
      OP_BIT_IMM_MEM: e = E_BIT_IMM_MEM;
      OP_BIT_REG_MEM: e = E_BIT_REG_MEM;
      OP_TST_IMM_REG: e = E_TST_IMM_REG;
      OP_TST_REG_REG: e = E_TST_REG_REG;
      OP_TST_IMM_MEM: e = E_TST_IMM_MEM;
      OP_TST_REG_MEM: e = E_TST_REG_MEM;
      OP_BRANCH:
      begin
        if (taken)
          e = E_BR_TAKEN;
        else if (disp == DISP_LONG)
          e = E_BR_L_NT;
        else if (disp == DISP_WORD)
          e = E_BR_W_NT;
        else
          e = E_BR_B_NT;
      end
      OP_LOOP_BRANCH:
      begin
        if (cond_true)
          e = loop_mode ? E_DB_TRUE_LP : E_DB_TRUE;
        else if (expired)
          e = loop_mode ? E_DB_EXP_LP : E_DB_EXP;
        else
          e = loop_mode ? E_DB_TAKEN_LP : E_DB_TAKEN;
      end
      OP_SR_LOGIC: e = E_SR_LOGIC;
      OP_CCR_LOGIC: e = E_CCR_LOGIC;
      OP_CHK: e = exc ? E_CHK_EX : E_CHK_OK;
      OP_TWO_BOUND_RANGE_CHECK: e = exc ? E_TWO_BOUND_RANGE_CHECK_EX : E_TWO_BOUND_RANGE_CHECK_OK;
      default: e = E_SHIFT_IMM;
    endcase
    select_entry = e;
  endfunction : select_entry

  function automatic logic [7:0] neg_mag(input logic signed [7:0] v);
    neg_mag = (v < 0) ? 8'(-v) : 8'h00;
  endfunction : neg_mag

  function automatic logic [TOTAL_W-1:0] sat_sub(
    input logic [TOTAL_W-1:0] a,
    input logic [TOTAL_W-1:0] b
  );
    sat_sub = (a > b + MIN_RUN_CLOCKS) ? a - b : MIN_RUN_CLOCKS;
  endfunction : sat_sub

  // ---------------------------------------------------------------
  // decode and sums
  // ---------------------------------------------------------------
  state_type state_reg;
  state_type state_next;
  logic signed [7:0] prev_tail_reg;
  logic [TOTAL_W-1:0] second_len_reg;
  logic cnt_busy;
  logic cnt_expire;
  logic [6:0] shift_clocks;

  wire logic take = start_in && (state_reg == ST_IDLE);
  wire logic is_two_bound_range_check = (op_in == OP_TWO_BOUND_RANGE_CHECK);
  wire logic formula_form = (op_in == OP_SHIFT_REG) || (op_in == OP_ROX_REG) ||
                            (op_in == OP_ROX_IMM);
  wire shift_mode_type shift_mode = (op_in == OP_ROX_REG) ? SHM_RX_REG :
                                    (op_in == OP_ROX_IMM) ? SHM_RX_IMM : SHM_QUAD;
  wire logic uses_ea = (op_in == OP_SHIFT_MEM) || (op_in == OP_BIT_IMM_MEM) ||
                       (op_in == OP_BIT_REG_MEM) || (op_in == OP_TST_IMM_MEM) ||
                       (op_in == OP_TST_REG_MEM) || (op_in == OP_CHK) || is_two_bound_range_check;
  wire logic uses_imm = (op_in == OP_BIT_IMM_REG) || (op_in == OP_BIT_IMM_MEM) ||
                        (op_in == OP_TST_IMM_REG) || (op_in == OP_TST_IMM_MEM);
  wire logic long_adj = is_two_bound_range_check && long_operand_in;

  wire timing_entry_type base_entry = select_entry(op_in, disp_size_in, branch_taken_in,
    cond_true_in, counter_expired_in, loop_mode_in, exception_in);

  // distance only matters for the formula forms; others use the fixed entry
  wire logic [TOTAL_W-1:0] op_cycles = formula_form ? {3'b000, shift_clocks} :
                                       base_entry.cycles;
  wire logic [TOTAL_W-1:0] adj_cycles = op_cycles + (long_adj ? LONG_EXTRA_CLOCKS : '0);
  wire logic [3:0] adj_reads = base_entry.rd + (long_adj ? LONG_EXTRA_READS : 4'h0);
  wire logic signed [7:0] adj_tail = base_entry.tail + (long_adj ? LONG_EXTRA_TAIL : 8'sh00);
  wire logic [TOTAL_W-1:0] ea_add = uses_ea ? {2'b00, ea_clocks_in} : '0;
  wire logic [TOTAL_W-1:0] imm_add = uses_imm ? {2'b00, imm_clocks_in} : '0;

  // listed totals already hold the bus breakdown; nothing is added for it
  wire logic [TOTAL_W-1:0] op_len = adj_cycles + ea_add + imm_add;
  wire logic [TOTAL_W-1:0] save_len = is_two_bound_range_check ? E_TWO_BOUND_RANGE_CHECK_SAVE.cycles : '0;
  wire logic [TOTAL_W-1:0] sum_total = save_len + op_len;
  wire logic signed [7:0] lead_head = is_two_bound_range_check ? E_TWO_BOUND_RANGE_CHECK_SAVE.head : base_entry.head;
  wire logic [TOTAL_W-1:0] overlap = {2'b00, neg_mag(prev_tail_reg)} +
                                     {2'b00, neg_mag(lead_head)};
  wire logic [TOTAL_W-1:0] first_len = is_two_bound_range_check ? save_len : op_len;
  wire logic [TOTAL_W-1:0] first_run = sat_sub(first_len, overlap);
  wire logic [3:0] adj_pf = base_entry.pf + (is_two_bound_range_check ? E_TWO_BOUND_RANGE_CHECK_SAVE.pf : 4'h0);
  wire logic [7:0] bus_clocks = BUS_CYCLE_CLOCKS *
                                ({4'h0, adj_reads} + {4'h0, adj_pf} + {4'h0, base_entry.wr});

  wire logic save_done = (state_reg == ST_SAVE) && cnt_expire;
  wire logic cnt_load = take || save_done;
  wire logic [TOTAL_W-1:0] cnt_value = take ? first_run : second_len_reg;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  shift_clock_calc u_shift_calc (
    .mode_in(shift_mode),
    .count_in(count_in),
    .clocks_out(shift_clocks)
  );

  cycle_counter #(.WIDTH(TOTAL_W)) u_counter (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .load_in(cnt_load),
    .value_in(cnt_value),
    .busy_out(cnt_busy),
    .expire_out(cnt_expire)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (take)
          state_next = is_two_bound_range_check ? ST_SAVE : ST_EXEC;
      ST_SAVE:
        if (cnt_expire)
          state_next = ST_EXEC;
      ST_EXEC:
        if (cnt_expire)
          state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  assign busy_out = (state_reg != ST_IDLE);
  assign done_out = (state_reg == ST_EXEC) && cnt_expire;

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      total_out <= '0;
      run_clocks_out <= '0;
      head_out <= 8'sh00;
      tail_out <= 8'sh00;
      reads_out <= 4'h0;
      prefetches_out <= 4'h0;
      writes_out <= 4'h0;
      bus_clocks_out <= 8'h00;
      prev_tail_reg <= 8'sh00;
      second_len_reg <= '0;
    end
    else if (take)
    begin
      total_out <= sum_total;
      run_clocks_out <= first_run + (is_two_bound_range_check ? op_len : '0);
      head_out <= lead_head;
      tail_out <= adj_tail;
      reads_out <= adj_reads;
      prefetches_out <= adj_pf;
      writes_out <= base_entry.wr;
      bus_clocks_out <= bus_clocks;
      prev_tail_reg <= adj_tail;
      second_len_reg <= op_len;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence seq_take(op_type o);
    take && (op_in == o);
  endsequence

  sequence seq_save_phase;
    (state_reg == ST_SAVE) [*3];
  endsequence

  chk_save_step_order: assert property (
    seq_take(OP_TWO_BOUND_RANGE_CHECK) ##0 (prev_tail_reg >= 0) |=> seq_save_phase ##1 (state_reg == ST_EXEC))
    else $error("save step did not last three clocks before execution");

  chk_quad_shift_top: assert property (
    seq_take(OP_SHIFT_REG) ##0 (count_in == 6'h3f) |=> (total_out == 10'h016))
    else $error("register shift at count 63 not 22 clocks");

  chk_quad_shift_floor: assert property (
    seq_take(OP_SHIFT_REG) ##0 (count_in == 6'h07) |=> (total_out == 10'h008))
    else $error("register shift at count 7 not 8 clocks");

  chk_imm_shift_fixed: assert property (
    seq_take(OP_SHIFT_IMM) |=> (total_out == 10'h006) && (prefetches_out == 4'h1) &&
      (writes_out == 4'h0))
    else $error("immediate shift not 6(0/1/0)");

  chk_mem_shift_sum: assert property (
    seq_take(OP_SHIFT_MEM) |=> (total_out == 10'h006 + {2'b00, $past(ea_clocks_in)}) &&
      (writes_out == 4'h1))
    else $error("memory shift not 6 plus fetch time with one write");

  chk_rox_reg_count: assert property (
    seq_take(OP_ROX_REG) ##0 (count_in == 6'h04) |=> (total_out == 10'h008))
    else $error("register rotate through extend at count 4 not 8");

  chk_rox_imm_count: assert property (
    seq_take(OP_ROX_IMM) ##0 (count_in == 6'h08) |=> (total_out == 10'h00a))
    else $error("immediate rotate through extend at count 8 not 10");

  chk_bit_imm_extra: assert property (
    seq_take(OP_BIT_IMM_REG) |=> (total_out == 10'h006 + {2'b00, $past(imm_clocks_in)}))
    else $error("immediate bit operation misses immediate fetch time");

  chk_bit_reg_forms: assert property (
    seq_take(OP_BIT_REG_REG) |=> (total_out == 10'h006) && (writes_out == 4'h0))
    else $error("register bit operation on data register not 6 clocks");

  chk_bit_test_reg: assert property (
    seq_take(OP_TST_REG_REG) |=> (total_out == 10'h004) && (prefetches_out == 4'h1))
    else $error("register bit test not 4(0/1/0)");

  chk_branch_taken: assert property (
    seq_take(OP_BRANCH) ##0 branch_taken_in |=> (total_out == 10'h008) &&
      (prefetches_out == 4'h2) && (head_out == 8'sh02))
    else $error("taken branch not 8(0/2/0)");

  chk_branch_long_nt: assert property (
    seq_take(OP_BRANCH) ##0 (!branch_taken_in && disp_size_in == DISP_LONG) |=>
      (total_out == 10'h006))
    else $error("long not-taken branch not 6 clocks");

  chk_loop_mode_taken: assert property (
    seq_take(OP_LOOP_BRANCH) ##0 (!cond_true_in && !counter_expired_in) |=>
      (total_out == 10'h00a) && (prefetches_out == ($past(loop_mode_in) ? 4'h0 : 4'h2)))
    else $error("taken loop branch prefetch count wrong");

  chk_status_full: assert property (
    seq_take(OP_SR_LOGIC) |=> (total_out == 10'h00c) && (prefetches_out == 4'h2))
    else $error("status register logic not 12(0/2/0)");

  chk_single_bound_ex: assert property (
    seq_take(OP_CHK) ##0 exception_in |=> (total_out == 10'h02a) && (reads_out == 4'h2) &&
      (writes_out == 4'h6) && (bus_clocks_out == 8'h14))
    else $error("single bound check exception not 42(2/2/6)");

  chk_long_operand: assert property (
    seq_take(OP_TWO_BOUND_RANGE_CHECK) ##0 (long_operand_in && !exception_in) |=> (tail_out == 8'sh02) &&
      (reads_out == 4'h2) && (total_out == 10'h017 + {2'b00, $past(ea_clocks_in)}))
    else $error("long operand adjustment missing");

  chk_run_overlap: assert property (
    take ##0 (prev_tail_reg < 0) |=> (run_clocks_out < total_out))
    else $error("negative tail did not shorten the run");

  chk_done_single: assert property (
    done_out |=> !busy_out && !done_out)
    else $error("unit stayed busy after done");

  chk_counter_busy: assert property (busy_out == cnt_busy)
    else $error("sequencer and phase counter disagree on busy");

endmodule : instr_timing_unit

`default_nettype wire

/* File: inc/timing_pkg.sv */
// package: operation codes, table entries and formula constants for the timing unit
`default_nettype none

package timing_pkg;

  // ---------------------------------------------------------------
  // widths and operation codes
  // ---------------------------------------------------------------
  localparam int TOTAL_W = 10;
  localparam int COUNT_W = 6;
  localparam int EA_W = 8;

  typedef enum logic [4:0] {
    OP_SHIFT_REG = 5'h00,
    OP_SHIFT_IMM = 5'h01,
    OP_ROX_REG = 5'h02,
    OP_ROX_IMM = 5'h03,
    OP_SHIFT_MEM = 5'h04,
    OP_BIT_IMM_REG = 5'h05,
    OP_BIT_REG_REG = 5'h06,
    OP_BIT_IMM_MEM = 5'h07,
    OP_BIT_REG_MEM = 5'h08,
    OP_TST_IMM_REG = 5'h09,
    OP_TST_REG_REG = 5'h0a,
    OP_TST_IMM_MEM = 5'h0b,
    OP_TST_REG_MEM = 5'h0c,
    OP_BRANCH = 5'h0d,
    OP_LOOP_BRANCH = 5'h0e,
    OP_SR_LOGIC = 5'h0f,
    OP_CCR_LOGIC = 5'h10,
    OP_CHK = 5'h11,
    OP_TWO_BOUND_RANGE_CHECK = 5'h12
  } op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAVE = 2'b01,
    ST_EXEC = 2'b10
  } state_type;

  typedef enum logic [1:0] {
    DISP_BYTE = 2'b00,
    DISP_WORD = 2'b01,
    DISP_LONG = 2'b10
  } disp_type;

  typedef enum logic [1:0] {
    SHM_QUAD = 2'b00,
    SHM_RX_REG = 2'b01,
    SHM_RX_IMM = 2'b10
  } shift_mode_type;

  typedef struct packed {
    logic signed [7:0] head;
    logic signed [7:0] tail;
    logic [TOTAL_W-1:0] cycles;
    logic [3:0] rd;
    logic [3:0] pf;
    logic [3:0] wr;
  } timing_entry_type;

  // ---------------------------------------------------------------
  // timing entries: head, tail, clocks, reads, prefetches, writes
  // ---------------------------------------------------------------
  localparam timing_entry_type E_SHIFT_REG = '{-8'sh02, 8'sh00, 10'h000, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_SHIFT_IMM = '{8'sh04, 8'sh00, 10'h006, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_SHIFT_MEM = '{8'sh00, 8'sh02, 10'h006, 4'h0, 4'h1, 4'h1};
  localparam timing_entry_type E_BIT_IMM_REG = '{8'sh02, 8'sh00, 10'h006, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_BIT_REG_REG = '{8'sh04, 8'sh00, 10'h006, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_BIT_IMM_MEM = '{8'sh01, 8'sh02, 10'h008, 4'h0, 4'h2, 4'h1};
  localparam timing_entry_type E_BIT_REG_MEM = '{8'sh02, 8'sh02, 10'h008, 4'h0, 4'h1, 4'h1};
  localparam timing_entry_type E_TST_IMM_REG = '{8'sh02, 8'sh00, 10'h004, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_TST_REG_REG = '{8'sh02, 8'sh00, 10'h004, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_TST_IMM_MEM = '{8'sh01, 8'sh00, 10'h004, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_TST_REG_MEM = '{8'sh02, 8'sh00, 10'h008, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_BR_TAKEN = '{8'sh02, -8'sh02, 10'h008, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_BR_B_NT = '{8'sh02, 8'sh00, 10'h004, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_BR_W_NT = '{8'sh00, 8'sh00, 10'h004, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_BR_L_NT = '{8'sh00, 8'sh00, 10'h006, 4'h0, 4'h3, 4'h1};
  localparam timing_entry_type E_DB_TRUE = '{8'sh01, 8'sh01, 10'h004, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_DB_TRUE_LP = '{8'sh04, 8'sh00, 10'h006, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_DB_EXP = '{8'sh02, 8'sh00, 10'h006, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_DB_EXP_LP = '{8'sh06, 8'sh00, 10'h008, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_DB_TAKEN = '{8'sh06, -8'sh02, 10'h00a, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_DB_TAKEN_LP = '{8'sh06, 8'sh00, 10'h00a, 4'h0, 4'h0, 4'h0};
  localparam timing_entry_type E_SR_LOGIC = '{8'sh00, -8'sh02, 10'h00c, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_CCR_LOGIC = '{8'sh02, 8'sh00, 10'h006, 4'h0, 4'h2, 4'h0};
  localparam timing_entry_type E_CHK_OK = '{8'sh02, 8'sh00, 10'h008, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_CHK_EX = '{8'sh02, -8'sh02, 10'h02a, 4'h2, 4'h2, 4'h6};
  localparam timing_entry_type E_TWO_BOUND_RANGE_CHECK_SAVE = '{8'sh01, 8'sh01, 10'h003, 4'h0, 4'h1, 4'h0};
  localparam timing_entry_type E_TWO_BOUND_RANGE_CHECK_OK = '{8'sh02, 8'sh00, 10'h012, 4'h1, 4'h0, 4'h0};
  localparam timing_entry_type E_TWO_BOUND_RANGE_CHECK_EX = '{8'sh02, -8'sh02, 10'h034, 4'h3, 4'h1, 4'h6};

  // ---------------------------------------------------------------
  // long operand, bus and shift formula constants
  // ---------------------------------------------------------------
  localparam logic [3:0] LONG_EXTRA_READS = 4'h1;
  localparam logic [TOTAL_W-1:0] LONG_EXTRA_CLOCKS = 10'h002;
  localparam logic signed [7:0] LONG_EXTRA_TAIL = 8'sh02;
  localparam logic [7:0] BUS_CYCLE_CLOCKS = 8'h02;
  localparam logic [6:0] SHIFT_MIN_CLOCKS = 7'h06;
  localparam logic [6:0] QUAD_BASE_CLOCKS = 7'h03;
  localparam logic [6:0] RX_REG_BASE_CLOCKS = 7'h03;
  localparam logic [6:0] RX_IMM_BASE_CLOCKS = 7'h02;
  localparam logic [TOTAL_W-1:0] MIN_RUN_CLOCKS = 10'h001;

endpackage : timing_pkg

`default_nettype wire

/* File: rtl/shift_clock_calc.sv */
// shift clock formula for the register-count form and rotate clock formulas for the register- and immediate-count forms
`default_nettype none

module shift_clock_calc
  import timing_pkg::*;
(
  input wire shift_mode_type mode_in,
  input wire logic [COUNT_W-1:0] count_in,
  output logic [6:0] clocks_out
);

  function automatic logic [6:0] floor_min(input logic [6:0] raw);
    floor_min = (raw < SHIFT_MIN_CLOCKS) ? SHIFT_MIN_CLOCKS : raw;
  endfunction : floor_min

  // ---------------------------------------------------------------
  // quarter count form: n/4 + n mod 4, plus parity fill
  // ---------------------------------------------------------------
  wire logic [4:0] quad_sum = {1'b0, count_in[5:2]} + {3'b000, count_in[1:0]};
  wire logic [6:0] quad_raw = QUAD_BASE_CLOCKS + {2'b00, quad_sum} + {6'h00, ~quad_sum[0]};
  wire logic [6:0] rx_reg_raw = RX_REG_BASE_CLOCKS + {1'b0, count_in} + {6'h00, ~count_in[0]};
  wire logic [6:0] rx_imm_raw = RX_IMM_BASE_CLOCKS + {1'b0, count_in} + {6'h00, count_in[0]};

  always_comb
  begin
    case (mode_in)
      SHM_QUAD: clocks_out = floor_min(quad_raw);
      SHM_RX_REG: clocks_out = floor_min(rx_reg_raw);
      SHM_RX_IMM: clocks_out = floor_min(rx_imm_raw);
      default: clocks_out = SHIFT_MIN_CLOCKS;
    endcase
  end

endmodule : shift_clock_calc

`default_nettype wire

/* File: rtl/cycle_counter.sv */
// down counter that times one execution phase in clocks
`default_nettype none

module cycle_counter
  import timing_pkg::*;
#(
  parameter int WIDTH = TOTAL_W
)
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] value_in,
  output logic busy_out,
  output logic expire_out
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  // a load in the expiring cycle chains the next phase with no gap
  assign cnt_next = load_in ? value_in : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
  assign busy_out = (cnt_reg != '0);
  assign expire_out = (cnt_reg == WIDTH'(1));

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

endmodule : cycle_counter

`default_nettype wire

/* File: verification/mem_model.sv */
// partner: external memory that turns operand reads into fetch clocks
`default_nettype none

module mem_model
  import timing_pkg::*;
(
  input wire logic [1:0] operand_reads_in,
  input wire logic long_in,
  output logic [7:0] fetch_clocks_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // zero wait states: slower memory would stretch the totals of only the operations that fetch an operand
  assign fetch_clocks_out = BUS_CYCLE_CLOCKS * (8'(operand_reads_in) << long_in);
endmodule : mem_model

`default_nettype wire

/* File: verification/testbench.sv */
// testbench: instruction timing unit against the documented clock counts
`default_nettype none

module testbench
  import timing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // stimulus, design and partner
  // ---------------------------------------------------------------
  logic sys_clk_in = 1'b0, arst_n_in = 1'b0, start_in = 1'b0, long_operand_in = 1'b0;
  logic branch_taken_in = 1'b0, cond_true_in = 1'b0, counter_expired_in = 1'b0;
  logic loop_mode_in = 1'b0, exception_in = 1'b0, prev_neg = 1'b0;
  op_type op_in = OP_SHIFT_IMM;
  disp_type disp_size_in = DISP_BYTE;
  logic [COUNT_W-1:0] count_in = '0;
  logic [1:0] reads_sel = 2'h0;
  logic [EA_W-1:0] ea_clocks_in, imm_clocks_in = 8'h00;
  logic busy_out, done_out;
  logic [TOTAL_W-1:0] total_out, run_clocks_out;
  int bad_count = 0, checked = 0, len = 0;
  int exp_q[$];
  instr_timing_unit instr_timing_unit_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .start_in(start_in), .op_in(op_in), .count_in(count_in), .disp_size_in(disp_size_in),
    .long_operand_in(long_operand_in), .branch_taken_in(branch_taken_in),
    .cond_true_in(cond_true_in), .counter_expired_in(counter_expired_in),
    .loop_mode_in(loop_mode_in), .exception_in(exception_in), .ea_clocks_in(ea_clocks_in),
    .imm_clocks_in(imm_clocks_in), .busy_out(busy_out), .done_out(done_out),
    .total_out(total_out), .run_clocks_out(run_clocks_out), .head_out(), .tail_out(),
    .reads_out(), .prefetches_out(), .writes_out(), .bus_clocks_out());
  mem_model mem_model_inst (.operand_reads_in(reads_sel), .long_in(long_operand_in),
    .fetch_clocks_out(ea_clocks_in));
  initial forever #20 sys_clk_in = ~sys_clk_in;
  // ---------------------------------------------------------------
  // expectations worked out from the listed clocks
  // ---------------------------------------------------------------
  function automatic int max_of(int a, int b);
    return (a > b) ? a : b;
  endfunction : max_of
  function automatic int exp_total();
    int n = count_in;
    // partner output is not yet settled when this runs: fetch time from the bus rule
    int e = int'(BUS_CYCLE_CLOCKS) * (int'(reads_sel) << long_operand_in);
    int m = imm_clocks_in;
    case (op_in)
      OP_SHIFT_REG: return max_of(3 + n / 4 + n % 4 + (n / 4 + n % 4 + 1) % 2, 6);
      OP_ROX_REG: return max_of(3 + n + (n + 1) % 2, 6);
      OP_ROX_IMM: return max_of(2 + n + n % 2, 6);
      OP_SHIFT_IMM, OP_BIT_REG_REG, OP_CCR_LOGIC: return 6;
      OP_SHIFT_MEM: return 6 + e;
      OP_BIT_IMM_REG: return 6 + m;
      OP_BIT_IMM_MEM: return 8 + e + m;
      OP_BIT_REG_MEM, OP_TST_REG_MEM: return 8 + e;
      OP_TST_IMM_REG: return 4 + m;
      OP_TST_REG_REG: return 4;
      OP_TST_IMM_MEM: return 4 + e + m;
      OP_BRANCH: return branch_taken_in ? 8 : (disp_size_in == DISP_LONG) ? 6 : 4;
      OP_LOOP_BRANCH: return cond_true_in ? (loop_mode_in ? 6 : 4) :
        counter_expired_in ? (loop_mode_in ? 8 : 6) : 10;
      OP_SR_LOGIC: return 12;
      OP_CHK: return e + (exception_in ? 42 : 8);
      OP_TWO_BOUND_RANGE_CHECK: return 3 + e + (exception_in ? 52 : 18) + (long_operand_in ? 2 : 0);
      default: return 0;
    endcase
  endfunction : exp_total
  // ---------------------------------------------------------------
  // driver, monitor and compares
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("counts: %0d compared, %0d mismatched", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic compare_total(input logic [TOTAL_W-1:0] got, input int want);
    checked++;
    if (got !== TOTAL_W'(want))
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t total got %h want %h", $time, got, TOTAL_W'(want));
    end
  endtask : compare_total
  task automatic compare_run(input logic [TOTAL_W-1:0] got, input int want);
    checked++;
    if (got !== TOTAL_W'(want))
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t run got %h want %h", $time, got, TOTAL_W'(want));
    end
  endtask : compare_run
  task automatic run_op(input bit refuse);
    int t = exp_total();
    int first = (op_in == OP_TWO_BOUND_RANGE_CHECK) ? 3 : t;
    int ov = 2 * int'(prev_neg) + ((op_in inside {OP_SHIFT_REG, OP_ROX_REG, OP_ROX_IMM}) ? 2 : 0);
    exp_q.push_back(t);
    exp_q.push_back(max_of(1, first - ov) + t - first);
    prev_neg = (op_in == OP_BRANCH && branch_taken_in) || op_in == OP_SR_LOGIC ||
      (op_in == OP_LOOP_BRANCH && !cond_true_in && !counter_expired_in && !loop_mode_in) ||
      (exception_in && (op_in == OP_CHK || (op_in == OP_TWO_BOUND_RANGE_CHECK && !long_operand_in)));
    start_in = 1'b1;
    @(negedge sys_clk_in);
    start_in = refuse;
    op_in = OP_SR_LOGIC;
    @(negedge sys_clk_in);
    start_in = 1'b0;
    for (int k = 0; busy_out !== 1'b0; k++)
    begin
      if (k > 200)
      begin
        bad_count++;
        summarize();
      end
      @(negedge sys_clk_in);
    end
  endtask : run_op
  always @(negedge sys_clk_in)
  begin
    if (busy_out === 1'b1)
      len++;
    if (done_out === 1'b1)
    begin
      if (exp_q.size() < 2)
        compare_total(total_out, -1);
      else
      begin
        compare_total(total_out, exp_q.pop_front());
        compare_run(run_clocks_out, exp_q[0]);
        compare_run(TOTAL_W'(len), exp_q.pop_front());
      end
      len = 0;
    end
  end
  initial
  begin
    void'($urandom(32'h8bbe));
    repeat (16) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    for (int rep = 0; rep < 3; rep++)
    begin
      for (int i = 0; i <= 18; i++)
      begin
        op_in = op_type'(i);
        // first two passes pin the corner cases that the assertions look for
        count_in = (rep == 0) ? ((i == 3) ? 6'h08 : 6'h3f) :
          (rep == 1) ? ((i == 0) ? 6'h07 : 6'h04) : COUNT_W'($urandom % ((i == 3) ? 9 : 64));
        {branch_taken_in, cond_true_in, counter_expired_in} =
          (rep == 0) ? 3'b000 : (rep == 1) ? 3'b100 : 3'($urandom);
        {loop_mode_in, exception_in, long_operand_in} =
          (rep == 0) ? 3'b001 : (rep == 1) ? 3'b110 : 3'($urandom);
        disp_size_in = (rep == 0) ? DISP_LONG : disp_type'($urandom % 3);
        reads_sel = 2'($urandom);
        imm_clocks_in = 8'($urandom % 16);
        run_op(rep == 1);
      end
      $display("test pass %0d finished", rep);
    end
    summarize();
  end
endmodule : testbench

`default_nettype wire
